/* File: rtl/iwd_pkg.sv */
// Constants, formats and opcode patterns of the instruction word decoder.
// Assumes a single 100 MHz sys_clk standing in for the oscillator clock.
// Notes on behaviour
// - Each instruction is one 14-bit word carrying opcode and operands.
// - Words split into byte-oriented, bit-oriented and literal/control formats.
// - Instructions take one instruction cycle unless an exception applies.
// - Both call forms take two instruction cycles.
// - Return, return with literal and return from interrupt take two cycles.
// - Jump, relative branch, branch by W and taken skips take two cycles.
// - Indirect access through a pointer into program memory adds one cycle.
// - One instruction cycle is four oscillator clocks.
// - File writes read the register first, then modify and store.
// - Bit 7 in byte ops selects W when 0, file when 1.
// - File address is the 7-bit field in bits 6 to 0.
// - Bit ops carry a 3-bit bit index beside the file address.
// - General literal ops carry an 8-bit immediate in the low bits.
// - Absolute call and jump carry an 11-bit target.
// - PC high latch load carries a 7-bit immediate in bits 6 to 0.
// - Bank select load carries a 5-bit immediate.
// - Relative branch carries a 9-bit offset.
// - Pointer offset ops carry pointer select and a 6-bit offset.
// - Pointer increment ops: select at bit 2, mode at bits 1 to 0.
// - Pointer select picks one of two indirect pointers, zero or one.
// - Don't-care bits are ignored when decoding; producers should emit zero.
// - Add with carry decodes from top bits 11 then 1101.
// - Decrement and skip takes one cycle, two when skipping.
package iwd_pkg;
    localparam int unsigned IWD_WORD_W = 14;
    localparam int unsigned IWD_OSC_PER_CYC = 4;
    localparam logic [1:0] IWD_PH_FIRST = 2'h0;
    localparam logic [1:0] IWD_PH_LAST = 2'(IWD_OSC_PER_CYC - 1);
    localparam logic [1:0] IWD_ONE_CYC = 2'h1;
    localparam logic [1:0] IWD_FMT_BYTE = 2'h0;
    localparam logic [1:0] IWD_FMT_BIT = 2'h1;
    localparam logic [1:0] IWD_FMT_LIT = 2'h2;
    localparam int unsigned IWD_D_POS = 7;
    localparam int unsigned IWD_PSEL_OFS_POS = 6;
    localparam int unsigned IWD_PSEL_INC_POS = 2;
    localparam logic [13:0] IWD_OP_RETURN = 14'h0008;
    localparam logic [13:0] IWD_OP_RETFI = 14'h0009;
    localparam logic [13:0] IWD_OP_CALL_VIA_WORKING_REG = 14'h000a;
    localparam logic [13:0] IWD_OP_BRW = 14'h000b;
    localparam logic [2:0] IWD_TOP_CALL = 3'h4;
    localparam logic [2:0] IWD_TOP_GOTO = 3'h5;
    localparam logic [5:0] IWD_TOP_RETURN_WITH_LITERAL = 6'h34;
    localparam logic [4:0] IWD_TOP_BRA = 5'h19;
    localparam logic [5:0] IWD_TOP_ADDC = 6'h3d;
    localparam logic [5:0] IWD_TOP_ASR = 6'h37;
    localparam logic [5:0] IWD_TOP_LSL = 6'h35;
    localparam logic [5:0] IWD_TOP_LSR = 6'h36;
    localparam logic [5:0] IWD_TOP_SUBB = 6'h3b;
    localparam logic [5:0] IWD_TOP_DECSZ = 6'h0b;
    localparam logic [5:0] IWD_TOP_INCSZ = 6'h0f;
    localparam logic [5:0] IWD_TOP_PTR_OFS = 6'h3f;
    localparam logic [9:0] IWD_TOP_PTR_INC = 10'h001;
    localparam logic [5:0] IWD_INDIRECT_HI = 6'h00;
    typedef enum logic [0:0] {IWD_RUN, IWD_FLUSH} iwd_state_t;
endpackage

/* File: rtl/iwd_decoder.sv */
// Instruction word decoder with instruction-cycle sequencing.
// Assumes the fetch path presents the next word on instr_word and advances on instr_take_q.
`timescale 1ns/1ns
module iwd_decoder
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fetch path and core status
    input wire logic [13:0] instr_word,
    input wire logic [1:0] ptr_in_prog,
    input wire logic skip_cond,
    // Sequencing
    output logic instr_take_q,
    output logic [1:0] phase_q,
    output logic [1:0] cycles_q,
    output logic flush_q,
    // Decoded word and format
    output logic [13:0] word_q,
    output logic [1:0] fmt_q,
    output logic add_carry_q,
    // Operand fields
    output logic dest_file,
    output logic [6:0] file_addr,
    output logic [2:0] bit_sel,
    output logic [7:0] lit8,
    output logic [10:0] lit11,
    output logic [6:0] lit7,
    output logic [4:0] lit5,
    output logic [8:0] lit9,
    output logic [5:0] lit6,
    output logic ptr_sel_q,
    output logic [1:0] ptr_mode,
    // Read-modify-write strobes
    output logic file_rd_q,
    output logic file_wr_q,
    output logic wreg_wr_q
);

    // ------------------------------------------------------------
    // Fields sliced from the held word
    // ------------------------------------------------------------
    assign dest_file = word_q[iwd_pkg::IWD_D_POS];
    assign file_addr = word_q[6:0];
    assign bit_sel = word_q[9:7];
    assign lit8 = word_q[7:0];
    assign lit11 = word_q[10:0];
    assign lit7 = word_q[6:0];
    assign lit5 = word_q[4:0];
    assign lit9 = word_q[8:0];
    assign lit6 = word_q[5:0];
    assign ptr_mode = word_q[1:0];

    // ------------------------------------------------------------
    // Decode of the incoming word
    // ------------------------------------------------------------
    logic [5:0] top;
    logic is_byte;
    logic is_bit;
    logic is_skip;
    logic is_flow;
    logic is_pinc;
    logic is_pofs;
    logic is_ind;
    logic ind_sel;
    logic n_sel;
    logic n_dest;
    logic n_rd;
    logic n_wf;
    logic n_ww;
    logic [1:0] n_cycles;
    logic [1:0] n_fmt;

    always_comb
    begin
        top = instr_word[13:8];
        // Only the bits that select an operation are compared
        is_byte = ((top[5:4] == 2'h0) && ((top[3:0] != 4'h0) || instr_word[7]))
            || (top == iwd_pkg::IWD_TOP_ADDC) || (top == iwd_pkg::IWD_TOP_ASR)
            || (top == iwd_pkg::IWD_TOP_LSL) || (top == iwd_pkg::IWD_TOP_LSR)
            || (top == iwd_pkg::IWD_TOP_SUBB);
        is_bit = (top[5:4] == 2'h1);
        if (is_byte)
        begin
            n_fmt = iwd_pkg::IWD_FMT_BYTE;
        end
        else if (is_bit)
        begin
            n_fmt = iwd_pkg::IWD_FMT_BIT;
        end
        else
        begin
            n_fmt = iwd_pkg::IWD_FMT_LIT;
        end
        is_skip = (top == iwd_pkg::IWD_TOP_DECSZ) || (top == iwd_pkg::IWD_TOP_INCSZ)
            || (is_bit && instr_word[11]);
        is_flow = (instr_word[13:11] == iwd_pkg::IWD_TOP_CALL)
            || (instr_word == iwd_pkg::IWD_OP_CALL_VIA_WORKING_REG)
            || (instr_word == iwd_pkg::IWD_OP_RETURN)
            || (instr_word == iwd_pkg::IWD_OP_RETFI)
            || (top == iwd_pkg::IWD_TOP_RETURN_WITH_LITERAL)
            || (instr_word[13:11] == iwd_pkg::IWD_TOP_GOTO)
            || (instr_word[13:9] == iwd_pkg::IWD_TOP_BRA)
            || (instr_word == iwd_pkg::IWD_OP_BRW);
        is_pinc = (instr_word[13:4] == iwd_pkg::IWD_TOP_PTR_INC);
        is_pofs = (top == iwd_pkg::IWD_TOP_PTR_OFS);
        if (is_pinc)
        begin
            n_sel = instr_word[iwd_pkg::IWD_PSEL_INC_POS];
        end
        else
        begin
            n_sel = instr_word[iwd_pkg::IWD_PSEL_OFS_POS];
        end
        // File address 0 or 1 is the indirect access port of pointer 0 or 1
        ind_sel = instr_word[0];
        is_ind = (is_byte || is_bit) && (instr_word[6:1] == iwd_pkg::IWD_INDIRECT_HI);
        if (is_pinc || is_pofs)
        begin
            ind_sel = n_sel;
            is_ind = 1'b1;
        end
        n_cycles = iwd_pkg::IWD_ONE_CYC;
        if (is_flow)
        begin
            n_cycles = n_cycles + 2'h1;
        end
        if (is_ind && ptr_in_prog[ind_sel])
        begin
            n_cycles = n_cycles + 2'h1;
        end
        n_dest = instr_word[iwd_pkg::IWD_D_POS];
        n_rd = is_byte || is_bit;
        n_wf = (is_byte && n_dest) || (is_bit && !instr_word[11]);
        n_ww = is_byte && !n_dest;
    end

    // ------------------------------------------------------------
    // Sequencing state
    // ------------------------------------------------------------
    iwd_pkg::iwd_state_t state_q;
    iwd_pkg::iwd_state_t state_d;
    logic [1:0] phase_d;
    logic [1:0] left_q;
    logic [1:0] left_d;
    logic [1:0] cycles_d;
    logic [13:0] word_d;
    logic [1:0] fmt_d;
    logic add_carry_d;
    logic ptr_sel_d;
    logic skip_q;
    logic skip_d;
    logic rd_en_q;
    logic rd_en_d;
    logic wf_en_q;
    logic wf_en_d;
    logic ww_en_q;
    logic ww_en_d;
    logic first_q;
    logic first_d;
    logic take_d;
    logic flush_d;
    logic file_rd_d;
    logic file_wr_d;
    logic wreg_wr_d;

    always_comb
    begin
        phase_d = phase_q + 2'h1;
        state_d = state_q;
        left_d = left_q;
        cycles_d = cycles_q;
        word_d = word_q;
        fmt_d = fmt_q;
        add_carry_d = add_carry_q;
        ptr_sel_d = ptr_sel_q;
        skip_d = skip_q;
        rd_en_d = rd_en_q;
        wf_en_d = wf_en_q;
        ww_en_d = ww_en_q;
        first_d = first_q;
        take_d = 1'b0;
        if (phase_q == iwd_pkg::IWD_PH_LAST)
        begin
            first_d = 1'b0;
            case (state_q)
                iwd_pkg::IWD_RUN:
                begin
                    if (left_q != iwd_pkg::IWD_ONE_CYC)
                    begin
                        left_d = left_q - 2'h1;
                    end
                    else if (skip_q && skip_cond)
                    begin
                        // Prefetched word is consumed but never executed
                        state_d = iwd_pkg::IWD_FLUSH;
                        left_d = iwd_pkg::IWD_ONE_CYC;
                        take_d = 1'b1;
                    end
                    else
                    begin
                        take_d = 1'b1;
                    end
                end
                iwd_pkg::IWD_FLUSH:
                begin
                    state_d = iwd_pkg::IWD_RUN;
                    take_d = 1'b1;
                end
                default:
                begin
                    state_d = iwd_pkg::IWD_RUN;
                end
            endcase
            if (take_d && (state_d == iwd_pkg::IWD_RUN))
            begin
                word_d = instr_word;
                fmt_d = n_fmt;
                add_carry_d = (top == iwd_pkg::IWD_TOP_ADDC);
                ptr_sel_d = n_sel;
                skip_d = is_skip;
                rd_en_d = n_rd;
                wf_en_d = n_wf;
                ww_en_d = n_ww;
                cycles_d = n_cycles;
                left_d = n_cycles;
                first_d = 1'b1;
            end
        end
        flush_d = (state_d == iwd_pkg::IWD_FLUSH);
        // Read in the first phase of the first cycle, store in the last
        file_rd_d = !flush_d && first_d && rd_en_d && (phase_d == iwd_pkg::IWD_PH_FIRST);
        file_wr_d = !flush_d && wf_en_d && (left_d == iwd_pkg::IWD_ONE_CYC)
            && (phase_d == iwd_pkg::IWD_PH_LAST);
        wreg_wr_d = !flush_d && ww_en_d && (left_d == iwd_pkg::IWD_ONE_CYC)
            && (phase_d == iwd_pkg::IWD_PH_LAST);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= iwd_pkg::IWD_RUN;
            phase_q <= iwd_pkg::IWD_PH_FIRST;
            left_q <= iwd_pkg::IWD_ONE_CYC;
            cycles_q <= iwd_pkg::IWD_ONE_CYC;
            word_q <= 14'h0000;
            fmt_q <= iwd_pkg::IWD_FMT_LIT;
            add_carry_q <= 1'b0;
            ptr_sel_q <= 1'b0;
            skip_q <= 1'b0;
            rd_en_q <= 1'b0;
            wf_en_q <= 1'b0;
            ww_en_q <= 1'b0;
            first_q <= 1'b1;
            instr_take_q <= 1'b0;
            flush_q <= 1'b0;
            file_rd_q <= 1'b0;
            file_wr_q <= 1'b0;
            wreg_wr_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            phase_q <= phase_d;
            left_q <= left_d;
            cycles_q <= cycles_d;
            word_q <= word_d;
            fmt_q <= fmt_d;
            add_carry_q <= add_carry_d;
            ptr_sel_q <= ptr_sel_d;
            skip_q <= skip_d;
            rd_en_q <= rd_en_d;
            wf_en_q <= wf_en_d;
            ww_en_q <= ww_en_d;
            first_q <= first_d;
            instr_take_q <= take_d;
            flush_q <= flush_d;
            file_rd_q <= file_rd_d;
            file_wr_q <= file_wr_d;
            wreg_wr_q <= wreg_wr_d;
        end
    end

endmodule // iwd_decoder

/* File: dv/iwd_props.sv */
// Port checker for the instruction word decoder.
// Assumes it is bound onto iwd_decoder.
`timescale 1ns/1ns
module iwd_props
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Sequencing
    input wire logic instr_take_q,
    input wire logic [1:0] phase_q,
    input wire logic [1:0] cycles_q,
    input wire logic flush_q,
    // Word and fields
    input wire logic [13:0] word_q,
    input wire logic [1:0] fmt_q,
    input wire logic add_carry_q,
    input wire logic dest_file,
    input wire logic [6:0] file_addr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] lit8,
    input wire logic [10:0] lit11,
    input wire logic [6:0] lit7,
    input wire logic [4:0] lit5,
    input wire logic [8:0] lit9,
    input wire logic [5:0] lit6,
    input wire logic ptr_sel_q,
    input wire logic [1:0] ptr_mode,
    // Strobes
    input wire logic file_rd_q,
    input wire logic file_wr_q,
    input wire logic wreg_wr_q
);
// ----------------------------------------
// Assertions
// ----------------------------------------
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
a_take_phase: assert property (instr_take_q |-> phase_q == 2'h0) else $error("take off phase 0");
a_phase_step: assert property (!$past(rst) |-> phase_q == $past(phase_q) + 2'h1)
    else $error("phase step");
a_take_gap: assert property (instr_take_q |=> !instr_take_q [*3]) else $error("takes too close");
a_rd_first: assert property (file_rd_q |-> instr_take_q && !flush_q) else $error("read misplaced");
a_wr_last: assert property ((file_wr_q || wreg_wr_q) |-> phase_q == 2'h3 && !flush_q)
    else $error("store misplaced");
a_rmw_order: assert property (file_wr_q && cycles_q == 2'h1 |-> $past(file_rd_q, 3))
    else $error("store without read");
a_dest_route: assert property (wreg_wr_q |-> !dest_file && fmt_q == iwd_pkg::IWD_FMT_BYTE)
    else $error("w store routing");
a_field_map: assert property (
    file_addr == word_q[6:0] && bit_sel == word_q[9:7] && lit8 == word_q[7:0]
    && lit11 == word_q[10:0] && lit7 == word_q[6:0] && lit5 == word_q[4:0] && lit9 == word_q[8:0]
    && lit6 == word_q[5:0] && ptr_mode == word_q[1:0] && dest_file == word_q[7]) else $error("field map");
a_ptr_sel: assert property (ptr_sel_q == (word_q[13:4] == 10'h001 ? word_q[2] : word_q[6]))
    else $error("pointer select");
a_add_carry: assert property (add_carry_q == (word_q[13:8] == iwd_pkg::IWD_TOP_ADDC))
    else $error("add with carry");
a_rd_on_take: assert property (instr_take_q && !flush_q && fmt_q != iwd_pkg::IWD_FMT_LIT |-> file_rd_q)
    else $error("file read missing");
a_wreg_store: assert property ((fmt_q == iwd_pkg::IWD_FMT_BYTE && !dest_file && !flush_q && phase_q == 2'h3)
    ##1 instr_take_q |-> $past(wreg_wr_q)) else $error("w store missing");
a_flush_len: assert property ($rose(flush_q) |-> instr_take_q ##0 flush_q [*4] ##1 !flush_q && instr_take_q)
    else $error("flush length");
endmodule // iwd_props
bind iwd_decoder iwd_props u_props (.sys_clk, .rst, .instr_take_q, .phase_q, .cycles_q, .flush_q, .word_q, .fmt_q,
    .add_carry_q, .dest_file, .file_addr, .bit_sel, .lit8, .lit11, .lit7, .lit5, .lit9, .lit6, .ptr_sel_q,
    .ptr_mode, .file_rd_q, .file_wr_q, .wreg_wr_q);

/* File: dv/iwd_fetch_model.sv */
// Program memory and fetch path model.
// Assumes the bench loads mem while reset is held.
`timescale 1ns/1ns
module iwd_fetch_model
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fetch handshake
    input wire logic instr_take_q,
    output logic [13:0] instr_word
);
// ----------------------------------------
// Program store
// ----------------------------------------
logic [13:0] mem [32];
logic [4:0] pc_q;
assign instr_word = mem[pc_q];
always_ff @(posedge sys_clk)
begin
    if (rst)
        pc_q <= 5'h00;
    else if (instr_take_q)
        pc_q <= pc_q + 5'h01;
end
endmodule // iwd_fetch_model

/* File: dv/testbench.sv */
// Self-checking bench for the instruction word decoder.
// Assumes the fetch model and bound checker are compiled first.
`timescale 1ns/1ns
module testbench;
// ----------------------------------------
// Harness
// ----------------------------------------
logic sys_clk = 1'b0;
logic rst = 1'b1;
logic [1:0] ptr_in_prog = 2'h0;
logic skip_cond = 1'b0;
logic [13:0] instr_word;
logic instr_take_q;
logic flush_q;
logic add_carry_q;
logic [13:0] word_q;
logic [1:0] fmt_q;
logic [1:0] cycles_q;
logic [1:0] tcy [32];
logic [13:0] tw [32];
logic tf [32];
logic [1:0] tfm [32];
logic tac [32];
int tt [32];
int nt = 0;
int cyc = 0;
int err_total = 0;
int samples_checked = 0;
always #5 sys_clk = ~sys_clk;
iwd_decoder DUT
(
    .sys_clk(sys_clk), .rst(rst), .instr_word(instr_word), .ptr_in_prog(ptr_in_prog), .skip_cond(skip_cond),
    .instr_take_q(instr_take_q), .phase_q(), .cycles_q(cycles_q), .flush_q(flush_q), .word_q(word_q), .fmt_q(fmt_q),
    .add_carry_q(add_carry_q), .dest_file(), .file_addr(), .bit_sel(), .lit8(), .lit11(), .lit7(), .lit5(),
    .lit9(), .lit6(), .ptr_sel_q(), .ptr_mode(), .file_rd_q(), .file_wr_q(), .wreg_wr_q()
);
iwd_fetch_model fm (.sys_clk(sys_clk), .rst(rst), .instr_take_q(instr_take_q), .instr_word(instr_word));
// Records every take with its cycle
always @(posedge sys_clk)
begin
    cyc <= cyc + 1;
    if (rst)
        nt <= 0;
    else if (instr_take_q)
    begin
        tw[nt] <= word_q;
        tf[nt] <= flush_q;
        tfm[nt] <= fmt_q;
        tac[nt] <= add_carry_q;
        tcy[nt] <= cycles_q;
        tt[nt] <= cyc;
        nt <= nt + 1;
    end
    if (cyc == 6000)
    begin
        err_total++;
        test_done();
    end
end
task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    samples_checked++;
    if (g !== e)
    begin
        err_total++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic run(input logic [13:0] w [$], input int n, input logic [1:0] p, input logic s);
    @(posedge sys_clk);
    rst <= 1'b1;
    ptr_in_prog <= p;
    skip_cond <= s;
    @(posedge sys_clk);
    foreach (fm.mem[i])
        fm.mem[i] = (i < w.size()) ? w[i] : 14'h0000;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    while (nt < n)
        @(posedge sys_clk);
endtask
task automatic cmp(input logic [13:0] w [$], input int c [$], input logic [15:0] f);
    for (int i = 0; i < w.size(); i++)
    begin
        chk("word", w[i], tw[i]);
        chk("flush", 14'(f[i]), 14'(tf[i]));
        chk("gap", 14'(4 * c[i]), 14'(tt[i + 1] - tt[i]));
        chk("cycles", 14'(c[i]), 14'(tcy[i]));
    end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_cycles();
    logic [13:0] w [$] = '{14'h0785, 14'h0705, 14'h3d85, 14'h1405, 14'h3012, 14'h0b85, 14'h2005,
        14'h000a, 14'h0008, 14'h3412, 14'h0009, 14'h2805, 14'h3205, 14'h000b};
    int c [$] = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2};
    logic [1:0] fe [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    run(w, 15, 2'h0, 1'b0);
    cmp(w, c, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
        chk("format", 14'(fe[i]), 14'(tfm[i]));
        chk("carry op", 14'(i == 2), 14'(tac[i]));
    end
endtask
task automatic t_indirect();
    logic [13:0] w [$] = '{14'h0780, 14'h0781, 14'h0014, 14'h0010, 14'h3f45, 14'h3f05, 14'h1481};
    int c [$] = '{1, 2, 2, 1, 2, 1, 2};
    run(w, 8, 2'h2, 1'b0);
    cmp(w, c, 16'h0000);
endtask
task automatic t_skip();
    logic [13:0] w [$] = '{14'h0b85, 14'h0780, 14'h1c05, 14'h0781, 14'h0f85, 14'h0700, 14'h3012};
    logic [13:0] e [$] = '{14'h0b85, 14'h0b85, 14'h1c05, 14'h1c05, 14'h0f85, 14'h0f85, 14'h3012};
    int c [$] = '{1, 1, 1, 1, 1, 1, 1};
    run(w, 8, 2'h0, 1'b1);
    cmp(e, c, 16'h002a);
endtask
initial
begin
    t_cycles();
    t_indirect();
    t_skip();
    test_done();
end
endmodule // testbench
